// ---- core/oas_pkg.sv ----
// Shared constants, types and helpers of the operand access sequencer
package oas_pkg;

	// ------------------------------------------------------------
	// Addresses, opcodes and fields
	// ------------------------------------------------------------
	localparam logic [15:0] OAS_TRAP_VEC_PC = 16'h0018;
	localparam logic [15:0] OAS_TRAP_VEC_PS = 16'h001A;
	localparam logic [15:0] OAS_WORD_STEP = 16'h0002;
	localparam logic [15:0] OAS_PS_RESET = 16'h0000;
	localparam logic [3:0] OAS_OP_COPY = 4'h1;
	localparam logic [3:0] OAS_OP_ADD = 4'h6;
	localparam logic [7:0] OAS_OP_TRAP = 8'h88;
	localparam logic [2:0] OAS_SP_IDX = 3'h6;
	localparam logic [2:0] OAS_PC_IDX = 3'h7;
	localparam int OAS_CC_N = 3;
	localparam int OAS_CC_Z = 2;
	localparam int OAS_CC_V = 1;
	localparam int OAS_CC_C = 0;

	// Addressing modes
	localparam logic [2:0] OAS_M_REG = 3'h0;
	localparam logic [2:0] OAS_M_DEF = 3'h1;
	localparam logic [2:0] OAS_M_INC = 3'h2;
	localparam logic [2:0] OAS_M_INCDEF = 3'h3;
	localparam logic [2:0] OAS_M_DEC = 3'h4;
	localparam logic [2:0] OAS_M_DECDEF = 3'h5;
	localparam logic [2:0] OAS_M_IDX = 3'h6;
	localparam logic [2:0] OAS_M_IDXDEF = 3'h7;

	// Phase indexes of the cycle accounting
	localparam logic [2:0] OAS_PH_FETCH = 3'h0;
	localparam logic [2:0] OAS_PH_SRC = 3'h1;
	localparam logic [2:0] OAS_PH_DST = 3'h2;
	localparam logic [2:0] OAS_PH_WB = 3'h3;
	localparam logic [2:0] OAS_PH_IMPL = 3'h4;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int OAS_CLK_PERIOD_NS = 10;
	localparam int OAS_REG_EXTRA_NS = 180;
	localparam int OAS_REG_EXTRA_CYC =
		(OAS_REG_EXTRA_NS + OAS_CLK_PERIOD_NS - 1) / OAS_CLK_PERIOD_NS;

	typedef enum logic [4:0] {
		OAS_S_START, OAS_S_FETCH, OAS_S_DECODE, OAS_S_EXTRA, OAS_S_AMODE,
		OAS_S_AIDX, OAS_S_AIND, OAS_S_AIMM, OAS_S_SRD, OAS_S_DRD,
		OAS_S_EXEC, OAS_S_WR, OAS_S_TSP1, OAS_S_TPU1, OAS_S_TSP2,
		OAS_S_TPU2, OAS_S_TV1, OAS_S_TV2, OAS_S_DONE
	} oas_state_t;

	// Mode field of an operand, source when dst is low
	function automatic logic [2:0] oas_mode(input logic [15:0] ir,
		input logic dst);
		return dst ? ir[5:3] : ir[11:9];
	endfunction

	// Register field of an operand
	function automatic logic [2:0] oas_reg(input logic [15:0] ir,
		input logic dst);
		return dst ? ir[2:0] : ir[8:6];
	endfunction

	// Word address step up or down
	function automatic logic [15:0] oas_step(input logic [15:0] v,
		input logic up);
		return up ? 16'(v + OAS_WORD_STEP) : 16'(v - OAS_WORD_STEP);
	endfunction

endpackage : oas_pkg

// ---- core/oas_regbank.sv ----
// Eight general registers, two read ports and one write port
`timescale 1ns/100ps
`default_nettype none
module oas_regbank
	import oas_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	oas_rf_if.bank rf
);

	typedef struct packed {
		logic [7:0][15:0] r;
	} oas_bank_t;

	oas_bank_t q;
	oas_bank_t next_q;

	// Single write per cycle keeps the bank a plain flop array
	always_comb begin
		next_q = q;
		if (rf.we) begin
			next_q.r[rf.wa] = rf.wd;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// Reads see the old value during a write cycle
	assign rf.rd_a = q.r[rf.ra_a];
	assign rf.rd_b = q.r[rf.ra_b];

endmodule // oas_regbank
`default_nettype wire

// ---- core/oas_rf_if.sv ----
// Register bank access channel between sequencer core and bank
`timescale 1ns/100ps
`default_nettype none
interface oas_rf_if;
	logic [2:0] ra_a;
	logic [2:0] ra_b;
	logic [15:0] rd_a;
	logic [15:0] rd_b;
	logic we;
	logic [2:0] wa;
	logic [15:0] wd;
	modport core (output ra_a, output ra_b, output we, output wa,
		output wd, input rd_a, input rd_b);
	modport bank (input ra_a, input ra_b, input we, input wa, input wd,
		output rd_a, output rd_b);
endinterface : oas_rf_if
`default_nettype wire

// ---- core/oas_sequencer.sv ----
// Operand access and execution sequencer, top level
`timescale 1ns/100ps
`default_nettype none
module oas_sequencer
	import oas_pkg::*;
#(
	parameter bit REG_EXTRA_EN = 1'b0,
	parameter int REG_EXTRA_CYC = OAS_REG_EXTRA_CYC
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	input wire logic MEM_ACK_I,
	input wire logic [15:0] MEM_RDATA_I,
	output logic MEM_REQ_O,
	output logic MEM_WE_O,
	output logic MEM_ISTREAM_O,
	output logic [15:0] MEM_ADDR_O,
	output logic [15:0] MEM_WDATA_O,
	output logic INSTR_DONE_O,
	output logic UNSUPPORTED_O,
	output logic [15:0] INSTR_CYCLES_O,
	output logic [3:0] ISTREAM_RD_CNT_O,
	output logic [3:0] DATA_RD_CNT_O,
	output logic [3:0] DATA_WR_CNT_O,
	output logic [15:0] PROCESSOR_STATUS_O
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (REG_EXTRA_CYC < 1 || REG_EXTRA_CYC > 255) begin : g_bad_extra
		$error("REG_EXTRA_CYC must lie in 1..255");
	end

	typedef struct packed {
		oas_state_t st;
		logic which;
		logic [15:0] ir;
		logic [15:0] ps;
		logic [15:0] maddr;
		logic [15:0] mwdata;
		logic [15:0] saddr;
		logic [15:0] daddr;
		logic [15:0] sval;
		logic [15:0] dval;
		logic sval_ok;
		logic ind_is;
		logic unsup;
		logic [7:0] xcnt;
		logic [4:0][15:0] cyc;
		logic [3:0] n_is;
		logic [3:0] n_rd;
		logic [3:0] n_wr;
	} oas_core_t;

	oas_core_t q;
	oas_core_t next_q;
	oas_rf_if rf();

	logic [2:0] cur_mode;
	logic [2:0] cur_reg;
	logic is_copy;
	logic is_add;
	logic is_trap;
	logic src_mem;
	logic dst_mem;
	logic mem_done;
	logic [2:0] phase;
	logic addr_done;
	logic [15:0] ea;
	logic [15:0] sop;
	logic [15:0] dop;
	logic [16:0] sum;
	logic [15:0] res;

	oas_regbank u_bank (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.rf(rf.bank)
	);

	// ------------------------------------------------------------
	// Decode of the held instruction
	// ------------------------------------------------------------
	assign cur_mode = oas_mode(q.ir, q.which);
	assign cur_reg = oas_reg(q.ir, q.which);
	assign is_copy = (q.ir[15:12] == OAS_OP_COPY);
	assign is_add = (q.ir[15:12] == OAS_OP_ADD);
	assign is_trap = (q.ir[15:8] == OAS_OP_TRAP);
	assign src_mem = (oas_mode(q.ir, 1'b0) != OAS_M_REG);
	assign dst_mem = (oas_mode(q.ir, 1'b1) != OAS_M_REG);

	// Port A follows the operand being resolved (SP in the trap pushes), port B watches PC; in EXEC they read source and destination
	assign rf.ra_a = (q.st == OAS_S_EXEC) ? oas_reg(q.ir, 1'b0) :
		(q.st == OAS_S_TSP1 || q.st == OAS_S_TSP2) ? OAS_SP_IDX : cur_reg;
	assign rf.ra_b = (q.st == OAS_S_EXEC) ? oas_reg(q.ir, 1'b1) : OAS_PC_IDX;

	// ------------------------------------------------------------
	// Memory port
	// ------------------------------------------------------------
	always_comb begin
		case (q.st)
			OAS_S_FETCH, OAS_S_AIDX, OAS_S_AIND, OAS_S_AIMM, OAS_S_SRD,
			OAS_S_DRD, OAS_S_WR, OAS_S_TPU1, OAS_S_TPU2, OAS_S_TV1,
			OAS_S_TV2: MEM_REQ_O = 1'b1;
			default: MEM_REQ_O = 1'b0;
		endcase
	end
	assign MEM_WE_O = (q.st == OAS_S_WR || q.st == OAS_S_TPU1 ||
		q.st == OAS_S_TPU2);
	assign MEM_ISTREAM_O = (q.st == OAS_S_FETCH || q.st == OAS_S_AIDX ||
		q.st == OAS_S_AIMM || (q.st == OAS_S_AIND && q.ind_is));
	assign mem_done = MEM_REQ_O && MEM_ACK_I;
	assign MEM_ADDR_O = q.maddr;
	assign MEM_WDATA_O = q.mwdata;

	// Phase the current cycle is charged to
	always_comb begin
		case (q.st)
			OAS_S_FETCH, OAS_S_DECODE: phase = OAS_PH_FETCH;
			OAS_S_EXTRA, OAS_S_SRD: phase = OAS_PH_SRC;
			OAS_S_AMODE, OAS_S_AIDX, OAS_S_AIND, OAS_S_AIMM:
				phase = q.which ? OAS_PH_DST : OAS_PH_SRC;
			OAS_S_DRD: phase = OAS_PH_DST;
			OAS_S_WR: phase = OAS_PH_WB;
			default: phase = OAS_PH_IMPL;
		endcase
	end

	// Execute datapath: operands, sum and result
	assign sop = q.sval_ok ? q.sval : rf.rd_a;
	assign dop = dst_mem ? q.dval : rf.rd_b;
	assign sum = 17'(sop) + 17'(dop);
	assign res = is_add ? sum[15:0] : sop;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_q = q;
		rf.we = 1'b0;
		rf.wa = cur_reg;
		rf.wd = 16'h0000;
		addr_done = 1'b0;
		ea = 16'h0000;
		if (q.st != OAS_S_START && q.st != OAS_S_DONE) begin
			next_q.cyc[phase] = 16'(q.cyc[phase] + 16'h0001);
		end
		if (mem_done && q.st != OAS_S_FETCH) begin
			if (MEM_WE_O) begin
				next_q.n_wr = 4'(q.n_wr + 4'h1);
			end else if (MEM_ISTREAM_O) begin
				next_q.n_is = 4'(q.n_is + 4'h1);
			end else begin
				next_q.n_rd = 4'(q.n_rd + 4'h1);
			end
		end
		case (q.st)
			OAS_S_START, OAS_S_DONE: begin
				next_q.st = OAS_S_FETCH;
				next_q.maddr = rf.rd_b;
				next_q.which = 1'b0;
				next_q.sval_ok = 1'b0;
				next_q.unsup = 1'b0;
				next_q.cyc = '0;
				next_q.n_is = 4'h0;
				next_q.n_rd = 4'h0;
				next_q.n_wr = 4'h0;
			end
			OAS_S_FETCH: begin
				if (mem_done) begin
					next_q.ir = MEM_RDATA_I;
					rf.we = 1'b1;
					rf.wa = OAS_PC_IDX;
					rf.wd = oas_step(rf.rd_b, 1'b1);
					next_q.st = OAS_S_DECODE;
				end
			end
			OAS_S_DECODE: begin
				next_q.xcnt = 8'h00;
				if (is_trap) begin
					next_q.st = OAS_S_TSP1;
				end else if (is_copy || is_add) begin
					if (REG_EXTRA_EN && !src_mem && dst_mem) begin
						next_q.st = OAS_S_EXTRA;
					end else begin
						next_q.st = OAS_S_AMODE;
					end
				end else begin
					next_q.unsup = 1'b1;
					next_q.st = OAS_S_DONE;
				end
			end
			OAS_S_EXTRA: begin
				next_q.xcnt = 8'(q.xcnt + 8'h01);
				if (q.xcnt == 8'(REG_EXTRA_CYC - 1)) begin
					next_q.st = OAS_S_AMODE;
				end
			end
			OAS_S_AMODE: begin
				next_q.ind_is = 1'b0;
				case (cur_mode)
					OAS_M_REG: addr_done = 1'b1;
					OAS_M_DEF: begin
						ea = rf.rd_a;
						addr_done = 1'b1;
					end
					OAS_M_INC: begin
						rf.we = 1'b1;
						rf.wd = oas_step(rf.rd_a, 1'b1);
						// Source immediate is addressed in place
						if (cur_reg == OAS_PC_IDX && !q.which) begin
							next_q.maddr = rf.rd_a;
							next_q.st = OAS_S_AIMM;
						end else begin
							ea = rf.rd_a;
							addr_done = 1'b1;
						end
					end
					OAS_M_INCDEF: begin
						rf.we = 1'b1;
						rf.wd = oas_step(rf.rd_a, 1'b1);
						next_q.maddr = rf.rd_a;
						next_q.ind_is = (cur_reg == OAS_PC_IDX);
						next_q.st = OAS_S_AIND;
					end
					OAS_M_DEC: begin
						rf.we = 1'b1;
						rf.wd = oas_step(rf.rd_a, 1'b0);
						ea = oas_step(rf.rd_a, 1'b0);
						addr_done = 1'b1;
					end
					OAS_M_DECDEF: begin
						rf.we = 1'b1;
						rf.wd = oas_step(rf.rd_a, 1'b0);
						next_q.maddr = oas_step(rf.rd_a, 1'b0);
						next_q.st = OAS_S_AIND;
					end
					default: begin
						next_q.maddr = rf.rd_b;
						next_q.st = OAS_S_AIDX;
					end
				endcase
			end
			OAS_S_AIDX: begin
				if (mem_done) begin
					rf.we = 1'b1;
					rf.wa = OAS_PC_IDX;
					rf.wd = oas_step(rf.rd_b, 1'b1);
					ea = 16'(MEM_RDATA_I + ((cur_reg == OAS_PC_IDX) ?
						oas_step(rf.rd_a, 1'b1) : rf.rd_a));
					if (cur_mode == OAS_M_IDXDEF) begin
						next_q.maddr = ea;
						next_q.st = OAS_S_AIND;
					end else begin
						addr_done = 1'b1;
					end
				end
			end
			OAS_S_AIND: begin
				if (mem_done) begin
					ea = MEM_RDATA_I;
					addr_done = 1'b1;
				end
			end
			OAS_S_AIMM: begin
				if (mem_done) begin
					next_q.sval = MEM_RDATA_I;
					next_q.sval_ok = 1'b1;
					addr_done = 1'b1;
				end
			end
			OAS_S_SRD: begin
				if (mem_done) begin
					next_q.sval = MEM_RDATA_I;
					next_q.sval_ok = 1'b1;
					next_q.maddr = q.daddr;
					next_q.st = (is_add && dst_mem) ? OAS_S_DRD :
						OAS_S_EXEC;
				end
			end
			OAS_S_DRD: begin
				if (mem_done) begin
					next_q.dval = MEM_RDATA_I;
					next_q.st = OAS_S_EXEC;
				end
			end
			OAS_S_EXEC: begin
				next_q.ps[OAS_CC_N] = res[15];
				next_q.ps[OAS_CC_Z] = (res == 16'h0000);
				next_q.ps[OAS_CC_V] = is_add &&
					(sop[15] == dop[15]) && (res[15] != sop[15]);
				if (is_add) begin
					next_q.ps[OAS_CC_C] = sum[16];
				end
				if (dst_mem) begin
					next_q.maddr = q.daddr;
					next_q.mwdata = res;
					next_q.st = OAS_S_WR;
				end else begin
					rf.we = 1'b1;
					rf.wa = oas_reg(q.ir, 1'b1);
					rf.wd = res;
					next_q.st = OAS_S_DONE;
				end
			end
			OAS_S_WR: begin
				if (mem_done) begin
					next_q.st = OAS_S_DONE;
				end
			end
			OAS_S_TSP1, OAS_S_TSP2: begin
				rf.we = 1'b1;
				rf.wa = OAS_SP_IDX;
				rf.wd = oas_step(rf.rd_a, 1'b0);
				next_q.maddr = oas_step(rf.rd_a, 1'b0);
				next_q.mwdata = (q.st == OAS_S_TSP1) ? q.ps : rf.rd_b;
				next_q.st = (q.st == OAS_S_TSP1) ? OAS_S_TPU1 :
					OAS_S_TPU2;
			end
			OAS_S_TPU1: begin
				if (mem_done) begin
					next_q.st = OAS_S_TSP2;
				end
			end
			OAS_S_TPU2: begin
				if (mem_done) begin
					next_q.maddr = OAS_TRAP_VEC_PC;
					next_q.st = OAS_S_TV1;
				end
			end
			OAS_S_TV1: begin
				if (mem_done) begin
					rf.we = 1'b1;
					rf.wa = OAS_PC_IDX;
					rf.wd = MEM_RDATA_I;
					next_q.maddr = OAS_TRAP_VEC_PS;
					next_q.st = OAS_S_TV2;
				end
			end
			OAS_S_TV2: begin
				if (mem_done) begin
					next_q.ps = MEM_RDATA_I;
					next_q.st = OAS_S_DONE;
				end
			end
			default: next_q.st = OAS_S_START;
		endcase
		// source then destination address, then source read
		if (addr_done) begin
			if (!q.which) begin
				next_q.saddr = ea;
				next_q.which = 1'b1;
				next_q.st = OAS_S_AMODE;
			end else begin
				next_q.daddr = ea;
				if (src_mem && !next_q.sval_ok) begin
					next_q.maddr = q.saddr;
					next_q.st = OAS_S_SRD;
				end else if (is_add && dst_mem) begin
					next_q.maddr = ea;
					next_q.st = OAS_S_DRD;
				end else begin
					next_q.st = OAS_S_EXEC;
				end
			end
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			q <= '0;
			q.st <= OAS_S_START;
			q.ps <= OAS_PS_RESET;
		end else begin
			q <= next_q;
		end
	end

	// ------------------------------------------------------------
	// Status outputs
	// ------------------------------------------------------------
	assign INSTR_DONE_O = (q.st == OAS_S_DONE);
	assign UNSUPPORTED_O = q.unsup;
	assign INSTR_CYCLES_O = 16'(q.cyc[0] + q.cyc[1] + q.cyc[2] + q.cyc[3] +
		q.cyc[4]);
	assign ISTREAM_RD_CNT_O = q.n_is;
	assign DATA_RD_CNT_O = q.n_rd;
	assign DATA_WR_CNT_O = q.n_wr;
	assign PROCESSOR_STATUS_O = q.ps;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);

	sequence s_push_end;
		q.st == OAS_S_TPU2 && MEM_ACK_I;
	endsequence
	sequence s_vec_load;
		q.st == OAS_S_TV1 && MEM_ADDR_O == OAS_TRAP_VEC_PC;
	endsequence

	src_no_write_a:
	assert property ((q.st == OAS_S_SRD || !q.which && !is_trap) &&
		MEM_REQ_O |-> !MEM_WE_O)
		else $error("write issued during source access");
	trap_vector_a:
	assert property (s_push_end |=> s_vec_load)
		else $error("trap vector not loaded after pushes");
	trap_counts_a:
	assert property (INSTR_DONE_O && is_trap |-> DATA_WR_CNT_O == 4'h2 &&
		DATA_RD_CNT_O == 4'h2 && ISTREAM_RD_CNT_O == 4'h0)
		else $error("trap access counts wrong");
	fetch_first_a:
	assert property (INSTR_DONE_O |=> MEM_REQ_O && MEM_ISTREAM_O &&
		q.st == OAS_S_FETCH)
		else $error("instruction did not start with fetch");
	reg_pair_add_a:
	assert property (q.st == OAS_S_EXEC && is_add && !src_mem && !dst_mem
		|-> rf.we ##1 INSTR_DONE_O)
		else $error("register add not single cycle");
	reg_direct_a:
	assert property (INSTR_DONE_O && is_copy && !src_mem && !dst_mem |->
		ISTREAM_RD_CNT_O == 4'h0 && DATA_RD_CNT_O == 4'h0 &&
		DATA_WR_CNT_O == 4'h0)
		else $error("register-direct copy touched memory");
	autoinc_a:
	assert property (INSTR_DONE_O && is_copy && !dst_mem &&
		oas_mode(q.ir, 1'b0) == OAS_M_INC && q.ir[8:6] != OAS_PC_IDX |->
		DATA_RD_CNT_O == 4'h1 && ISTREAM_RD_CNT_O == 4'h0)
		else $error("autoincrement source counts wrong");
	immediate_a:
	assert property (INSTR_DONE_O && is_copy && !dst_mem &&
		oas_mode(q.ir, 1'b0) == OAS_M_INC && q.ir[8:6] == OAS_PC_IDX |->
		DATA_RD_CNT_O == 4'h0 && ISTREAM_RD_CNT_O == 4'h1)
		else $error("immediate source counts wrong");
	absolute_a:
	assert property (INSTR_DONE_O && is_copy && !dst_mem &&
		oas_mode(q.ir, 1'b0) == OAS_M_INCDEF && q.ir[8:6] == OAS_PC_IDX |->
		DATA_RD_CNT_O == 4'h1 && ISTREAM_RD_CNT_O == 4'h1)
		else $error("absolute source counts wrong");
	index_def_a:
	assert property (INSTR_DONE_O && is_copy && !dst_mem &&
		oas_mode(q.ir, 1'b0) == OAS_M_IDXDEF |->
		DATA_RD_CNT_O == 4'h2 && ISTREAM_RD_CNT_O == 4'h1)
		else $error("indexed deferred source counts wrong");
	add_dst_read_a:
	assert property (q.st == OAS_S_DRD && MEM_ACK_I |=>
		q.st == OAS_S_EXEC ##1 q.st == OAS_S_WR)
		else $error("add did not write back after reading destination");

endmodule // oas_sequencer
`default_nettype wire

// ---- verification/oas_mem_model.sv ----
// Behavioural main memory on the far side of the sequencer port
`timescale 1ns/100ps
`default_nettype none
module oas_mem_model
	import oas_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic [3:0] wait_i,
	output logic ack_o,
	output logic [15:0] rdata_o
);
	// ----------------------------------------
	// Storage and answer
	// ----------------------------------------
	logic [15:0] mem [0:255];
	logic [3:0] cnt;
	logic [15:0] last;

	// Answer after wait_i cycles of a standing request
	assign ack_o = req_i && (cnt == wait_i);
	// Stale word inverted so a late sample never matches
	assign rdata_o = (ack_o && !we_i) ? mem[addr_i[8:1]] : ~last;

	// Wait counter, write port and stale word
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 4'h0;
			last <= 16'h0000;
		end else if (ack_o) begin
			cnt <= 4'h0;
			last <= rdata_o;
			if (we_i) begin
				mem[addr_i[8:1]] <= wdata_i;
			end
		end else if (req_i) begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule // oas_mem_model
`default_nettype wire

// ---- verification/test_operand_access_sequencer.sv ----
// Self-checking bench of the operand access sequencer
`timescale 1ns/100ps
`default_nettype none
module test_operand_access_sequencer
	import oas_pkg::*;
;
	typedef struct packed {
		logic [5:0] src;
		logic hx;
		logic [15:0] x;
		logic [15:0] v;
		logic [3:0] is;
		logic [3:0] dr;
		logic dm;
	} oas_row_t;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] wt = 4'h0;
	logic ack, req, we, is, done;
	logic [15:0] rdata, addr, wdata, cyc, status;
	logic [3:0] n_is_o, n_dr_o, n_wr_o;
	int fail_count = 0;
	int comparisons = 0;
	int n [3];
	int s_n [3];
	int gap, s_gap;
	logic [17:0] ops [$];
	logic [17:0] s_ops [$];
	// Source mode, extension word, operand, stream reads, data reads
	oas_row_t rows [12] = '{
		'{6'h02, 1'b0, 16'h0000, 16'h0040, 4'h0, 4'h0, 1'b1},
		'{6'h0A, 1'b0, 16'h0000, 16'h0050, 4'h0, 4'h1, 1'b1},
		'{6'h12, 1'b0, 16'h0000, 16'h0050, 4'h0, 4'h1, 1'b1},
		'{6'h1A, 1'b0, 16'h0000, 16'hA5A1, 4'h0, 4'h2, 1'b1},
		'{6'h22, 1'b0, 16'h0000, 16'h0052, 4'h0, 4'h1, 1'b1},
		'{6'h2A, 1'b0, 16'h0000, 16'hA5A2, 4'h0, 4'h2, 1'b1},
		'{6'h32, 1'b1, 16'h0004, 16'h0054, 4'h1, 4'h1, 1'b1},
		'{6'h3A, 1'b1, 16'h0004, 16'hA5A4, 4'h1, 4'h2, 1'b1},
		'{6'h17, 1'b1, 16'h1234, 16'h1234, 4'h1, 4'h0, 1'b1},
		'{6'h1F, 1'b1, 16'h0050, 16'hA5A1, 4'h1, 4'h1, 1'b1},
		'{6'h27, 1'b0, 16'h0000, 16'h0000, 4'h0, 4'h1, 1'b0},
		'{6'h2F, 1'b0, 16'h0000, 16'h0000, 4'h0, 4'h2, 1'b0}};

	// ----------------------------------------
	// Clock, design and memory
	// ----------------------------------------
	initial begin
		forever #5 clk = ~clk;
	end

	oas_sequencer #(.REG_EXTRA_EN(1'b1), .REG_EXTRA_CYC(2)) oas_sequencer_i (
		.CLK_SYS_I(clk), .RST_N_I(rst_n), .MEM_ACK_I(ack),
		.MEM_RDATA_I(rdata), .MEM_REQ_O(req), .MEM_WE_O(we),
		.MEM_ISTREAM_O(is), .MEM_ADDR_O(addr), .MEM_WDATA_O(wdata),
		.INSTR_DONE_O(done), .UNSUPPORTED_O(), .INSTR_CYCLES_O(cyc),
		.ISTREAM_RD_CNT_O(n_is_o), .DATA_RD_CNT_O(n_dr_o),
		.DATA_WR_CNT_O(n_wr_o), .PROCESSOR_STATUS_O(status));

	oas_mem_model oas_mem_model_i (.clk_i(clk), .rst_n_i(rst_n),
		.req_i(req), .we_i(we), .addr_i(addr), .wdata_i(wdata),
		.wait_i(wt), .ack_o(ack), .rdata_o(rdata));

	// Tally of port traffic per instruction, independent of the counters
	// Sampled mid-cycle so the done pulse is seen while it stands
	always @(negedge clk) begin
		if (!rst_n) begin
			n = '{0, 0, 0};
			gap = 0;
			ops.delete();
		end else begin
			if (req && ack) begin
				n[we ? 2 : (is ? 0 : 1)]++;
				ops.push_back({we, is, addr});
			end
			if (done) begin
				s_n = n;
				s_ops = ops;
				s_gap = gap;
				n = '{0, 0, 0};
				gap = 0;
				ops.delete();
			end else begin
				gap++;
			end
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [17:0] seen,
		input logic [17:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Reset with a fresh memory image; memory waits w cycles
	task automatic boot(input logic [15:0] p [$], input logic [3:0] w);
		@(posedge clk);
		rst_n <= 1'b0;
		wt <= w;
		for (int i = 0; i < 256; i++) begin
			oas_mem_model_i.mem[i] = 16'hFFFF;
		end
		foreach (p[i]) begin
			oas_mem_model_i.mem[i] = p[i];
		end
		oas_mem_model_i.mem[8'h0C] = 16'h0060;
		oas_mem_model_i.mem[8'h0D] = 16'h000F;
		oas_mem_model_i.mem[8'h1F] = 16'h0052;
		oas_mem_model_i.mem[8'h20] = 16'h0050;
		oas_mem_model_i.mem[8'h22] = 16'h0054;
		oas_mem_model_i.mem[8'h28] = 16'hA5A1;
		oas_mem_model_i.mem[8'h29] = 16'hA5A2;
		oas_mem_model_i.mem[8'h2A] = 16'hA5A4;
		oas_mem_model_i.mem[8'h40] = 16'h0100;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
	endtask

	// Bounded wait for cnt completion pulses; returns inside the last one
	task automatic run(input int cnt);
		int k;
		k = 0;
		repeat (cnt) begin
			do begin
				@(negedge clk);
				k++;
			end while (done !== 1'b1 && k < 2000);
		end
		if (done !== 1'b1) begin
			fail_count++;
			complete_run();
		end
		#1;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Every source mode: to memory with fast memory (PC autodecrement rows to R0), to R0 with slow memory
	task automatic test_src_modes();
		oas_row_t r;
		logic [15:0] p [$];
		for (int w = 0; w < 4; w += 3) begin
			foreach (rows[j]) begin
				r = rows[j];
				r.dm = r.dm && (w == 0);
				p = '{16'h15C2, 16'h0040, {4'h1, r.src, r.dm ? 6'h1F : 6'h00}};
				if (r.hx) p.push_back(r.x);
				if (r.dm) p.push_back(16'h0080);
				boot(p, 4'(w));
				run(2);
				check("is cnt", n_is_o, r.is + r.dm);
				check("rd cnt", n_dr_o, r.dr);
				check("wr cnt", n_wr_o, r.dm);
				check("is port", s_n[0], r.is + r.dm + 1);
				check("rd port", s_n[1], r.dr);
				check("cycles", cyc, s_gap);
				if (j == 0 && r.dm) check("extra cyc", cyc, 16'h0009);
				if (r.dm) check("last op", s_ops[$], {2'b10, 16'h0080});
				if (r.dm) check("value", oas_mem_model_i.mem[8'h40], r.v);
			end
		end
		$display("end test_src_modes");
	endtask

	// Add to memory, then a register pair add against a register copy
	task automatic test_add();
		logic [15:0] c0;
		boot('{16'h15C2, 16'h0040, 16'h609F, 16'h0080}, 4'h1);
		run(2);
		check("add rd", n_dr_o, 4'h1);
		check("add dst rd", s_ops[2], {2'b00, 16'h0080});
		check("add wr", s_ops[$], {2'b10, 16'h0080});
		check("add sum", oas_mem_model_i.mem[8'h40], 16'h0140);
		boot('{16'h1001, 16'h6040}, 4'h0);
		run(1);
		c0 = cyc;
		check("copy cyc", c0, 16'h0005);
		run(1);
		check("add cyc", cyc, c0);
		check("add cnt", {n_is_o, n_dr_o, n_wr_o}, 12'h000);
		$display("end test_add");
	endtask

	// Software trap after loading the stack pointer
	task automatic test_trap();
		logic [17:0] e [4];
		boot('{16'h15C6, 16'h0100, 16'h8800}, 4'h2);
		run(2);
		e = '{{2'b10, 16'h00FE}, {2'b10, 16'h00FC},
			{2'b00, OAS_TRAP_VEC_PC}, {2'b00, OAS_TRAP_VEC_PS}};
		check("trap fetch", s_ops[0], {2'b01, 16'h0004});
		foreach (e[i]) check("trap op", s_ops[i + 1], e[i]);
		check("trap cnt", {n_is_o, n_dr_o, n_wr_o}, 12'h022);
		check("push status", oas_mem_model_i.mem[8'h7F], 16'h0000);
		check("push pc", oas_mem_model_i.mem[8'h7E], 16'h0006);
		check("new status", status, 16'h000F);
		// Vector PC shows up as the next fetch address
		@(posedge clk);
		#1;
		check("new pc", addr, 16'h0060);
		$display("end test_trap");
	endtask

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Watchdog well beyond the thousand or so cycles the tests need
	initial begin
		#200000;
		fail_count++;
		complete_run();
	end

	initial begin
		test_src_modes();
		test_add();
		test_trap();
		complete_run();
	end
endmodule // test_operand_access_sequencer
`default_nettype wire
